// ==== hw/iso_rx_dv_and_link_enh_regs.sv ====
// register bank and per-context frame sync control for video receive
`timescale 1ns/1ps
`default_nettype none
`include "iso_rx_dv_map.svh"
module iso_rx_dv_and_link_enh_regs (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic global_reset_pin,
    // axi4-lite slave
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output iso_rx_dv_pkg::axi_resp_t s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output iso_rx_dv_pkg::axi_resp_t s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // eeprom preload of link bits
    input wire logic eeprom_load,
    input wire logic [1:0] eeprom_link_bits,
    // receive context 0 and 1 status
    input wire logic [1:0] ctx_isoch_header,
    input wire logic [1:0] ctx_bufferfill,
    input wire logic [3:0] ctx_desc_b,
    // received quadlet stream, per context
    input wire logic [1:0] rx_valid,
    input wire logic [1:0] rx_first,
    input wire logic [63:0] rx_quadlet,
    // per-context receive control, plus the async_tx_pipeline_off link bit
    output logic [1:0] rx_store,
    output logic [1:0] rx_frame_branch,
    output logic async_tx_pipeline_off,
    output iso_rx_dv_pkg::ctx_mode_t [1:0] ctx_mode
);
    import iso_rx_dv_pkg::*;

    logic any_rst;
    logic [31:0] vid_q;
    logic [31:0] lnk_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic aw_have_q;
    logic w_have_q;
    logic do_write;
    logic [1:0] vid_strip_ok;
    logic [1:0] vid_sync_ok;

    // power-on and global pin both clear the bank
    assign any_rst = rst | global_reset_pin;

    function automatic logic [31:0] apply_setclr(input logic [31:0] cur,
        input logic [31:0] wd, input logic set, input logic clr,
        input logic [31:0] msk);
        logic [31:0] r;
        r = cur;
        if (set) begin
            r = cur | (wd & msk);
        end
        if (clr) begin
            r = cur & ~(wd & msk);
        end
        return r;
    endfunction

    // write address and data taken in either order
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            awaddr_q <= 12'h000;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end else if (s_awvalid && s_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_awaddr;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            w_have_q <= 1'b0;
            wdata_q <= 32'h00000000;
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end else if (s_wvalid && s_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_wdata & {{8{s_wstrb[3]}}, {8{s_wstrb[2]}},
                {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
        end
    end

    assign do_write = aw_have_q && w_have_q && !s_bvalid;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_awready <= 1'b0;
            s_wready <= 1'b0;
        end else begin
            s_awready <= !aw_have_q && !(s_awvalid && s_awready) && !s_bvalid;
            s_wready <= !w_have_q && !(s_wvalid && s_wready) && !s_bvalid;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_bvalid <= 1'b1;
            unique case (awaddr_q)
                `VID_SET_OFS, `VID_CLR_OFS, `LNK_SET_OFS,
                `LNK_CLR_OFS, `LNK_CFG_OFS: s_bresp <= RESP_OKAY;
                default: s_bresp <= RESP_SLVERR;
            endcase
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // reserved bits are masked off, so they always read zero, except link bit 14, which LNK_WMASK and the eeprom preload leave writable
    always_ff @(posedge sys_clk or posedge any_rst) begin
        if (any_rst) begin
            vid_q <= `VID_RESET;
        end else if (do_write) begin
            vid_q <= apply_setclr(vid_q, wdata_q,
                awaddr_q == `VID_SET_OFS, awaddr_q == `VID_CLR_OFS,
                `VID_WMASK);
        end
    end

    // one storage behind the set, clear and config views
    always_ff @(posedge sys_clk or posedge any_rst) begin
        if (any_rst) begin
            lnk_q <= `LNK_RESET;
        end else if (eeprom_load) begin
            lnk_q <= {16'h0000, eeprom_link_bits, 14'h0000};
        end else if (do_write && awaddr_q == `LNK_CFG_OFS) begin
            lnk_q <= wdata_q & `LNK_WMASK;
        end else if (do_write) begin
            lnk_q <= apply_setclr(lnk_q, wdata_q,
                awaddr_q == `LNK_SET_OFS, awaddr_q == `LNK_CLR_OFS,
                `LNK_WMASK);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rresp <= RESP_OKAY;
            unique case (s_araddr)
                `VID_SET_OFS, `VID_CLR_OFS: s_rdata <= vid_q;
                `LNK_SET_OFS, `LNK_CLR_OFS, `LNK_CFG_OFS: s_rdata <= lnk_q;
                `CTX_IN_OFS: s_rdata <= {24'h000000, 2'b00,
                    ctx_isoch_header, 2'b00, rx_store};
                default: begin
                    s_rdata <= 32'h00000000;
                    s_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_rvalid) begin
            if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end else begin
            s_arready <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge any_rst) begin
        if (any_rst) begin
            async_tx_pipeline_off <= 1'b0;
        end else begin
            async_tx_pipeline_off <= lnk_q[`LNK_PIPE_OFF_BIT];
        end
    end

    assign vid_strip_ok[0] = vid_q[`VID_STRIP0_BIT] && !ctx_isoch_header[0];
    assign vid_strip_ok[1] = vid_q[`VID_STRIP1_BIT] && !ctx_isoch_header[1];
    assign vid_sync_ok[0] = vid_q[`VID_SYNC0_BIT] && vid_strip_ok[0];
    assign vid_sync_ok[1] = vid_q[`VID_SYNC1_BIT] && vid_strip_ok[1];

    // frame sync engine repeats once per context
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ctx
            rx_state_t st_q;
            logic [1:0] qcnt_q;
            logic [31:0] qd;
            logic tag_hit;
            logic sync_on;
            assign qd = rx_quadlet[32*c +: 32];
            // first byte 1Fh, low nibble of second byte 7h
            assign tag_hit = qd[31:24] == `FRAME_TAG_B0 &&
                qd[19:16] == `FRAME_TAG_LO && qcnt_q == 2'h2;
            assign sync_on = vid_sync_ok[c] && ctx_bufferfill[c] &&
                ctx_desc_b[2*c +: 2] == `BFILL_B_SYNC;

            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    qcnt_q <= 2'h0;
                end else if (rx_valid[c] && rx_first[c]) begin
                    qcnt_q <= 2'h1;
                end else if (rx_valid[c] && qcnt_q != 2'h3) begin
                    qcnt_q <= qcnt_q + 2'h1;
                end
            end

            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    st_q <= RX_IDLE;
                end else if (!sync_on) begin
                    // re-arm: the next enable waits for a fresh frame start
                    st_q <= RX_IDLE;
                end else begin
                    unique case (st_q)
                        RX_IDLE, RX_WAIT_FRAME: begin
                            if (rx_valid[c] && tag_hit) begin
                                st_q <= RX_STORE;
                            end else begin
                                st_q <= RX_WAIT_FRAME;
                            end
                        end
                        RX_STORE: st_q <= RX_STORE;
                        default: st_q <= RX_IDLE;
                    endcase
                end
            end

            // header quadlets (count 0,1) are dropped when stripping
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    rx_store[c] <= 1'b0;
                    rx_frame_branch[c] <= 1'b0;
                    ctx_mode[c] <= '0;
                end else begin
                    rx_store[c] <= rx_valid[c] && !(vid_strip_ok[c] &&
                        (rx_first[c] || qcnt_q == 2'h1)) &&
                        (st_q == RX_STORE || !sync_on || tag_hit);
                    // out-of-place tag: a frame start mid-frame
                    rx_frame_branch[c] <= sync_on && st_q == RX_STORE &&
                        rx_valid[c] && tag_hit;
                    ctx_mode[c] <= '{header_strip: vid_strip_ok[c],
                        frame_sync: vid_sync_ok[c]};
                end
            end
        end
    endgenerate

    property p_rsvd_zero;
        @(posedge sys_clk) disable iff (any_rst)
        (vid_q[3:2] == 2'b00) && (lnk_q[31:16] == 16'h0000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bits not zero");

    property p_sync_gate;
        @(posedge sys_clk) disable iff (any_rst)
        ctx_mode[1].frame_sync |-> ctx_mode[1].header_strip;
    endproperty
    a_sync_gate: assert property (p_sync_gate)
        else $error("sync enabled without strip");

    property p_pipe_follow;
        @(posedge sys_clk) disable iff (any_rst)
        $rose(lnk_q[15]) |=> async_tx_pipeline_off;
    endproperty
    a_pipe_follow: assert property (p_pipe_follow)
        else $error("pipeline off not followed");

    property p_bresp;
        @(posedge sys_clk) disable iff (rst)
        do_write |=> s_bvalid;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("no write response");

    property p_strip_head;
        @(posedge sys_clk) disable iff (any_rst)
        rx_valid[0] && rx_first[0] && vid_strip_ok[0] |=> !rx_store[0];
    endproperty
    a_strip_head: assert property (p_strip_head)
        else $error("header quadlet stored while stripping");

    property p_frame_wait;
        @(posedge sys_clk) disable iff (any_rst)
        g_ctx[1].sync_on && g_ctx[1].st_q != RX_STORE &&
            !g_ctx[1].tag_hit |=> !rx_store[1];
    endproperty
    a_frame_wait: assert property (p_frame_wait)
        else $error("data stored before frame start");
endmodule // iso_rx_dv_and_link_enh_regs
`default_nettype wire

// ==== hw/iso_rx_dv_map.svh ====
// register map constants for the video receive and link enhancement bank
`ifndef ISO_RX_DV_MAP_SVH
`define ISO_RX_DV_MAP_SVH
`define VID_SET_OFS 12'hA80
`define VID_CLR_OFS 12'hA84
`define LNK_SET_OFS 12'hA88
`define LNK_CLR_OFS 12'hA8C
`define LNK_CFG_OFS 12'hAF4
`define CTX_IN_OFS 12'hB00
`define VID_STRIP0_BIT 0
`define VID_SYNC0_BIT 1
`define VID_STRIP1_BIT 4
`define VID_SYNC1_BIT 5
`define LNK_RSVD14_BIT 14
`define LNK_PIPE_OFF_BIT 15
`define VID_WMASK 32'h00000033
`define LNK_WMASK 32'h0000C000
`define VID_RESET 32'h00000000
`define LNK_RESET 32'h00000000
`define BFILL_B_SYNC 2'h1
`define FRAME_TAG_B0 8'h1F
`define FRAME_TAG_LO 4'h7
`define ISOCH_HDR_BIT 30
`endif

// ==== hw/iso_rx_dv_pkg.sv ====
// types for the video receive and link enhancement bank
package iso_rx_dv_pkg;
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;
    typedef struct packed {
        logic header_strip;
        logic frame_sync;
    } ctx_mode_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_WAIT_FRAME = 2'b01,
        RX_STORE = 2'b10
    } rx_state_t;
endpackage

// ==== verification/tb_top.sv ====
// self-checking bench for the video receive and link enhancement bank
`timescale 1ns/1ps
`default_nettype none
`include "iso_rx_dv_map.svh"
module tb_top;
    import iso_rx_dv_pkg::*;
    logic sys_clk, rst, global_reset_pin, eeprom_load;
    logic [11:0] s_awaddr, s_araddr;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb, ctx_desc_b;
    axi_resp_t s_bresp, s_rresp;
    logic [1:0] eeprom_link_bits, ctx_isoch_header, ctx_bufferfill;
    logic [1:0] rx_valid, rx_first, rx_store, rx_frame_branch;
    logic [63:0] rx_quadlet;
    logic async_tx_pipeline_off;
    ctx_mode_t [1:0] ctx_mode;
    int failures = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic [1:0] rsp;
    int nbr = 0;
    iso_rx_dv_and_link_enh_regs iso_rx_dv_and_link_enh_regs_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .global_reset_pin(global_reset_pin),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .eeprom_load(eeprom_load),
        .eeprom_link_bits(eeprom_link_bits),
        .ctx_isoch_header(ctx_isoch_header),
        .ctx_bufferfill(ctx_bufferfill),
        .ctx_desc_b(ctx_desc_b),
        .rx_valid(rx_valid),
        .rx_first(rx_first),
        .rx_quadlet(rx_quadlet),
        .rx_store(rx_store),
        .rx_frame_branch(rx_frame_branch),
        .async_tx_pipeline_off(async_tx_pipeline_off),
        .ctx_mode(ctx_mode)
    );
    initial begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit ad, wd;
        ad = 0;
        wd = 0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1;
        s_wvalid <= 1;
        s_bready <= 1;
        while (!(ad && wd)) begin
            @(posedge sys_clk);
            if (!ad && s_awready === 1) begin
                ad = 1;
                s_awvalid <= 0;
            end
            if (!wd && s_wready === 1) begin
                wd = 1;
                s_wvalid <= 0;
            end
        end
        do @(posedge sys_clk); while (s_bvalid !== 1);
        rsp = s_bresp;
        s_bready <= 0;
        @(posedge sys_clk);
    endtask
    task automatic rdr(input logic [11:0] a);
        s_araddr <= a;
        s_arvalid <= 1;
        s_rready <= 1;
        do @(posedge sys_clk); while (s_arready !== 1);
        s_arvalid <= 0;
        while (s_rvalid !== 1) @(posedge sys_clk);
        rd = s_rdata;
        rsp = s_rresp;
        s_rready <= 0;
        @(posedge sys_clk);
    endtask
    // four quadlet packet; third quadlet optionally carries the frame tag
    task automatic pkt(input int c, input bit tag, output int n);
        n = 0;
        for (int q = 0; q < 7; q++) begin
            rx_valid[c] <= (q < 4);
            rx_first[c] <= (q == 0);
            rx_quadlet[32*c+:32] <= (q == 2 && tag) ? 32'h1FA70000 : 32'h1234;
            @(posedge sys_clk);
            if (rx_store[c] === 1) n++;
            if (rx_frame_branch[c] === 1) nbr++;
        end
    endtask
    task automatic t_regs();
        rdr(`VID_SET_OFS); chk(rd, 32'h0);
        rdr(`LNK_CLR_OFS); chk(rd, 32'h0);
        wr(`VID_SET_OFS, 32'hFFFFFFFF);
        rdr(`VID_CLR_OFS); chk(rd, 32'h33);
        wr(`VID_CLR_OFS, 32'h11);
        rdr(`VID_SET_OFS); chk(rd, 32'h22);
        wr(`VID_CLR_OFS, 32'hFFFFFFFF);
        // bit 14 is never written as one: it must stay zero
        wr(`LNK_SET_OFS, 32'hFFFFBFFF);
        rdr(`LNK_SET_OFS); chk(rd, 32'h8000);
        @(posedge sys_clk);
        chk(async_tx_pipeline_off, 1);
        wr(`LNK_CLR_OFS, 32'h8000);
        rdr(`LNK_CFG_OFS); chk(rd, 32'h0);
        wr(`LNK_CFG_OFS, 32'h8000);
        rdr(`LNK_CLR_OFS); chk(rd, 32'h8000);
        rdr(12'h010); chk(rsp, RESP_SLVERR);
        wr(12'h014, 32'h1); chk(rsp, RESP_SLVERR);
    endtask
    task automatic t_resets();
        wr(`LNK_SET_OFS, 32'h8000);
        global_reset_pin <= 1;
        @(posedge sys_clk);
        global_reset_pin <= 0;
        rdr(`LNK_SET_OFS); chk(rd, 32'h0);
        chk(async_tx_pipeline_off, 0);
        eeprom_link_bits <= 2'b10;
        eeprom_load <= 1;
        @(posedge sys_clk);
        eeprom_load <= 0;
        rdr(`LNK_SET_OFS); chk(rd, 32'h8000);
        wr(`LNK_CLR_OFS, 32'hC000);
    endtask
    task automatic t_mode();
        wr(`VID_SET_OFS, 32'h23);
        repeat (2) @(posedge sys_clk);
        chk(ctx_mode[0], 2'b11);
        chk(ctx_mode[1], 2'b00);
        ctx_isoch_header <= 2'b01;
        repeat (3) @(posedge sys_clk);
        chk(ctx_mode[0], 2'b00);
        rdr(`CTX_IN_OFS); chk(rd, 32'h10);
        ctx_isoch_header <= 2'b00;
        wr(`VID_CLR_OFS, 32'h33);
    endtask
    task automatic t_stream();
        int n;
        pkt(0, 0, n); chk(n, 4);
        wr(`VID_SET_OFS, 32'h01);
        pkt(0, 0, n); chk(n, 2);
        wr(`VID_CLR_OFS, 32'h01);
        wr(`VID_SET_OFS, 32'h10);
        pkt(1, 0, n); chk(n, 2);
        ctx_bufferfill <= 2'b10;
        ctx_desc_b <= {`BFILL_B_SYNC, 2'b00};
        wr(`VID_SET_OFS, 32'h20);
        pkt(1, 0, n); chk(n, 0);
        pkt(1, 1, n); chk(n, 2);
        chk(nbr, 0);
        // a second frame start while storing is out of place
        pkt(1, 1, n); chk(n, 2);
        chk(nbr, 1);
    endtask
    initial begin
        rst = 1;
        global_reset_pin = 0;
        eeprom_load = 0;
        eeprom_link_bits = 0;
        {s_awaddr, s_araddr, s_wdata} = 0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 0;
        s_wstrb = 4'hF;
        {ctx_isoch_header, ctx_bufferfill, ctx_desc_b} = 0;
        {rx_valid, rx_first, rx_quadlet} = 0;
        repeat (5) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        t_regs();
        t_resets();
        t_mode();
        t_stream();
        give_verdict();
    end
    // the whole run needs under two hundred cycles; the 20000-cycle limit allows ample slack
    initial begin
        #400000;
        failures++;
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
